// ===== include/relay_plugin_consts.vh
// constants for the relay plug-in register decode
`ifndef RELAY_PLUGIN_CONSTS_VH
`define RELAY_PLUGIN_CONSTS_VH
`define OFS_RELAY_PORT      10'h001
`define OFS_FIXED_CODE      10'h201
`define OFS_DESC_STREAM     10'h203
`define SLOT_SHIFT          10
`define SLOT_MIN            4'h1
`define SLOT_MAX            4'hC
`define AM_A24_LO           6'h38
`define AM_A24_HI           6'h3F
`define AM_A24_ALT_LO       6'h39
`define AM_A24_ALT_HI       6'h3E
`define RELAY_PORT_RESET    8'h00
`define BIT_FIRST_RELAY     0
`define BIT_SECOND_RELAY    1
`define DESC_PTR_RESET      8'h00
`define ID_TEXT_OFFSET      8'h23
`endif

// ===== logic/relay_plugin_register_decode.v
// register decode, relay drive and descriptor stream of the transfer-switch plug-in
`timescale 1ns/1ns
`include "relay_plugin_consts.vh"
module relay_plugin_register_decode #(
    parameter       DUAL        = 1,
    parameter [7:0] FIXED_CODE  = 8'h5A,   // arbitrary identity value
    parameter       DESC_DEPTH  = 64
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [23:0] carrier_offset,
    input  wire [3:0]  module_address,
    input  wire [5:0]  address_modifier,
    input  wire [23:0] bus_addr,
    input  wire        bus_wr,
    input  wire        bus_rd,
    input  wire [7:0]  bus_wdata,
    output reg  [7:0]  bus_rdata,
    output reg         bus_ack,
    output reg         first_transfer_relay,
    output reg         second_transfer_relay,
    output reg  [7:0]  module_list_char,
    output reg         module_list_valid,
    input  wire        module_list_query,
    output reg  [23:0] base_address
);

    reg  [7:0]  relay_control_port;
    reg  [7:0]  desc_ptr;
    reg  [7:0]  next_rdata;
    reg         is_a24;
    reg         slot_ok;
    reg  [23:0] next_base;
    reg  [9:0]  offset;
    reg         hit;
    reg  [7:0]  desc_byte;
    reg  [5:0]  q_idx;
    reg         q_busy;
    reg  [7:0]  q_char;

    // descriptor storage; identification text sits from ID_TEXT_OFFSET
    function [7:0] desc_rom;
        input [7:0] a;
        begin
            if (a >= `ID_TEXT_OFFSET && a < `ID_TEXT_OFFSET + 8'h12)
                desc_rom = DUAL ? 8'h44 : 8'h53;
            else
                desc_rom = a ^ 8'hA5;
        end
    endfunction

    // reply text: address digits space-padded to two characters, ": ", version text
    function [7:0] reply_char;
        input [5:0] i;
        input [3:0] m;
        begin
            case (i)
                6'd0:    reply_char = (m >= 4'hA) ? 8'h31 : 8'h30 + {4'h0, m};
                6'd1:    reply_char = (m >= 4'hA) ? 8'h30 + {4'h0, m - 4'hA} : 8'h20;
                6'd2:    reply_char = 8'h3A;
                6'd3:    reply_char = 8'h20;
                6'd4:    reply_char = 8'h52;
                6'd5:    reply_char = 8'h46;
                6'd6:    reply_char = 8'h20;
                6'd7:    reply_char = DUAL ? 8'h44 : 8'h53;
                6'd8:    reply_char = 8'h0A;
                default: reply_char = 8'h00;
            endcase
        end
    endfunction

    always @* begin
        is_a24    = (address_modifier >= `AM_A24_LO) && (address_modifier <= `AM_A24_HI);
        slot_ok   = (module_address >= `SLOT_MIN) && (module_address <= `SLOT_MAX);
        next_base = carrier_offset + ({20'h00000, module_address} << `SLOT_SHIFT);
        offset    = bus_addr[9:0] - next_base[9:0];
        hit       = is_a24 && slot_ok && bus_addr[23:10] == next_base[23:10] && bus_addr[0];
        desc_byte = (desc_ptr < DESC_DEPTH) ? desc_rom(desc_ptr) : 8'hFF;
        q_char    = reply_char(q_idx, module_address);
        next_rdata = 8'h00;
        case (offset)
            `OFS_RELAY_PORT:  next_rdata = ~relay_control_port;
            `OFS_FIXED_CODE:  next_rdata = FIXED_CODE;
            `OFS_DESC_STREAM: next_rdata = desc_byte;
            default:          next_rdata = 8'h00;
        endcase
    end

    // reply sequencer states
    localparam       REPLY_IDLE = 1'b0;
    localparam       REPLY_SEND = 1'b1;
    localparam [5:0] REPLY_LAST = 6'd8;

    // computed base shown to the carrier
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            base_address <= 24'h000000;
        end else begin
            base_address <= next_base;
        end
    end

    // one registered acknowledge per decoded strobe
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= hit && (bus_rd || bus_wr);
        end
    end

    // port register: written and read back at one offset
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            relay_control_port <= `RELAY_PORT_RESET;
        end else begin
            // other offsets ignore writes
            if (hit && bus_wr && offset == `OFS_RELAY_PORT) begin
                relay_control_port <= bus_wdata;
            end
        end
    end

    // read data holds until the next decoded read
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else begin
            if (hit && bus_rd) begin
                bus_rdata <= next_rdata;
            end
        end
    end

    // descriptor pointer: code read rewinds, descriptor read steps
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            desc_ptr <= `DESC_PTR_RESET;
        end else begin
            if (hit && bus_rd && offset == `OFS_FIXED_CODE) begin
                desc_ptr <= `DESC_PTR_RESET;
            end else if (hit && bus_rd && offset == `OFS_DESC_STREAM) begin
                desc_ptr <= desc_ptr + 8'h01;
            end
        end
    end

    // relay drive lags the port register by one clock
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_transfer_relay  <= 1'b0;
            second_transfer_relay <= 1'b0;
        end else begin
            first_transfer_relay  <= relay_control_port[`BIT_FIRST_RELAY];
            // single version leaves the second relay open
            second_transfer_relay <= (DUAL != 0) ? relay_control_port[`BIT_SECOND_RELAY] : 1'b0;
        end
    end

    // reply sequencer; a query while sending is ignored
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q_idx  <= 6'd0;
            q_busy <= REPLY_IDLE;
        end else begin
            case (q_busy)
                REPLY_IDLE: begin
                    if (module_list_query) begin
                        q_busy <= REPLY_SEND;
                        q_idx  <= 6'd0;
                    end
                end
                REPLY_SEND: begin
                    q_idx <= q_idx + 6'd1;
                    if (q_idx == REPLY_LAST) begin
                        q_busy <= REPLY_IDLE;
                    end
                end
                default: begin
                    q_busy <= REPLY_IDLE;
                end
            endcase
        end
    end

    // reply characters, one per clock while sending
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            module_list_char  <= 8'h00;
            module_list_valid <= 1'b0;
        end else begin
            module_list_valid <= (q_busy == REPLY_SEND);
            module_list_char  <= (q_busy == REPLY_SEND) ? q_char : 8'h00;
        end
    end

endmodule // relay_plugin_register_decode

// ===== verif/carrier_bus_master.sv
// carrier-side bus master issuing single-byte register cycles
`timescale 1ns/1ns
module carrier_bus_master (
    input wire        ref_clk, bus_ack,
    input wire [7:0]  bus_rdata,
    output reg        bus_wr = 0, bus_rd = 0,
    output reg [7:0]  bus_wdata = 8'h00,
    output reg [23:0] bus_addr = 24'h000000,
    output reg [5:0]  address_modifier = 6'h39
);
    // released address and data lines show inverted values, strobes drop to 0, so stale data is never mistaken for valid
    task cycle(input w, input [23:0] a, input [7:0] d, input [5:0] am, output [7:0] q, output ok);
        @(posedge ref_clk) #1;
        {bus_wr, bus_rd, bus_addr, bus_wdata, address_modifier} = {w, !w, a, d, am};
        @(posedge ref_clk) #1;
        q = bus_rdata;
        ok = bus_ack;
        {bus_wr, bus_rd, bus_addr, bus_wdata} = {2'b00, ~a, ~d};
    endtask
    task modify(input [23:0] a, input [7:0] m, input [7:0] v);
        reg [7:0] q;
        reg       ok;
        cycle(0, a, 8'h00, 6'h39, q, ok);
        cycle(1, a, (~q & m) | v, 6'h39, q, ok);
    endtask
endmodule // carrier_bus_master

// ===== verif/relay_plugin_properties.sv
// port assertions for the relay plug-in decode
`timescale 1ns/1ns
module relay_plugin_properties #(parameter [7:0] FIXED_CODE = 8'h5A) (
    input wire        ref_clk, rst, bus_wr, bus_rd, bus_ack, module_list_valid, module_list_query,
    input wire        first_transfer_relay, second_transfer_relay,
    input wire [23:0] carrier_offset, bus_addr, base_address,
    input wire [7:0]  bus_wdata, bus_rdata, module_list_char,
    input wire [5:0]  address_modifier,
    input wire [3:0]  module_address
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire hit = (bus_rd | bus_wr) && bus_addr[23:10] == base_address[23:10] && bus_addr[0]
        && address_modifier[5:3] == 3'h7 && module_address != 4'h0 && module_address <= 4'hC;
    wire [9:0] ofs = bus_addr[9:0];
    reg  [7:0] last_wr;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) last_wr <= 8'h00;
        else if (hit && bus_wr && ofs == 10'h001) last_wr <= bus_wdata;
    end
    a_ack_decoded: assert property (hit |=> bus_ack) else $error("no ack");
    a_no_stray: assert property (!hit |=> !bus_ack) else $error("stray ack");
    a_base_sum: assert property ($stable(carrier_offset) && $stable(module_address)
        |=> base_address == carrier_offset + {10'h000, module_address, 10'h000}) else $error("base");
    a_code_fixed: assert property (hit && bus_rd && ofs == 10'h201
        |=> bus_rdata == FIXED_CODE) else $error("code");
    a_port_inverted: assert property (hit && bus_rd && ofs == 10'h001
        |=> bus_rdata == ~$past(last_wr)) else $error("readback");
    a_relay_one: assert property (hit && bus_wr && ofs == 10'h001
        |=> ##1 first_transfer_relay == $past(bus_wdata[0], 2)) else $error("relay one");
    a_relay_two: assert property (hit && bus_wr && ofs == 10'h001
        |=> ##1 second_transfer_relay == $past(bus_wdata[1], 2)) else $error("relay two");
    a_reply_head: assert property (module_list_query && module_address < 4'hA
        |=> ##1 module_list_valid && module_list_char == 8'h30 + module_address ##1 module_list_valid[*8])
        else $error("reply");
endmodule // relay_plugin_properties
bind relay_plugin_register_decode relay_plugin_properties #(.FIXED_CODE(FIXED_CODE)) relay_plugin_properties_i (.*);

// ===== verif/test_relay_plugin_register_decode.sv
// self-checking bench for the relay plug-in register decode
`timescale 1ns/1ns
module test_relay_plugin_register_decode;
    reg        ref_clk = 0, rst = 1, module_list_query = 0, ok;
    reg [23:0] carrier_offset = 24'h204000;
    reg [3:0]  module_address = 4'h7;
    reg [7:0]  q, x1, x2;
    wire       bus_wr, bus_rd, bus_ack, first_transfer_relay, second_transfer_relay, module_list_valid;
    wire [23:0] bus_addr, base_address;
    wire [7:0] bus_wdata, bus_rdata, module_list_char;
    wire [5:0] address_modifier;
    integer    bad_count = 0, comparisons = 0;
    localparam [23:0] base_exp = 24'h205C00;
    relay_plugin_register_decode relay_plugin_register_decode_i (.*);
    carrier_bus_master carrier_bus_master_i (.*);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task chk(input [47:0] n, input [23:0] e, input [23:0] s);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %0s expected %h seen %h", n, e, s);
        end
    endtask
    task acc(input w, input [9:0] o, input [7:0] d);
        carrier_bus_master_i.cycle(w, base_exp + o, d, 6'h39, q, ok);
    endtask
    task port_test;
        acc(1, 10'h001, 8'h03);
        chk("base", base_exp, base_address);
        @(posedge ref_clk) #1;
        chk("relays", 2'b11, {second_transfer_relay, first_transfer_relay});
        acc(0, 10'h001, 8'h00);
        chk("port", 8'hFC, q);
        acc(1, 10'h201, 8'h00);
        carrier_bus_master_i.cycle(1, base_exp + 24'h000001, 8'h00, 6'h29, q, ok);
        chk("am", 0, ok);
        acc(1, 10'h000, 8'h00);
        chk("even", 0, ok);
        carrier_bus_master_i.modify(base_exp + 24'h000001, 8'hFE, 8'h00);
        @(posedge ref_clk) #1;
        chk("relays", 2'b10, {second_transfer_relay, first_transfer_relay});
        acc(1, 10'h001, 8'hFC);
        @(posedge ref_clk) #1;
        chk("unused", 0, {second_transfer_relay, first_transfer_relay});
    endtask
    task descriptor_test;
        acc(0, 10'h201, 8'h00);
        chk("code", 8'h5A, q);
        acc(0, 10'h203, 8'h00);
        x1 = q;
        acc(0, 10'h203, 8'h00);
        x2 = q;
        chk("advance", 1, x1 !== x2);
        acc(0, 10'h201, 8'h00);
        acc(0, 10'h203, 8'h00);
        chk("rewind", x1, q);
        acc(1, 10'h203, 8'h00);
        acc(0, 10'h203, 8'h00);
        chk("step", x2, q);
    endtask
    task query_test;
        @(posedge ref_clk) #1 module_list_query = 1;
        @(posedge ref_clk) #1 module_list_query = 0;
        @(posedge ref_clk) #1;
        chk("valid", 1, module_list_valid);
        chk("reply", 8'h37, module_list_char);
        @(posedge ref_clk) #1;
        chk("space", 8'h20, module_list_char);
        @(posedge ref_clk) #1;
        chk("colon", 8'h3A, module_list_char);
    endtask
    task print_verdict;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst = 0;
        port_test;
        descriptor_test;
        query_test;
        repeat (12) @(posedge ref_clk);
        print_verdict;
    end
    initial begin
        #5000;
        bad_count++;
        print_verdict;
    end
endmodule // test_relay_plugin_register_decode
